//--- rtl/tsr_filt.sv
`timescale 1ns/1ps
module tsr_filt #(
	parameter int W     = 2,
	parameter int DEPTH = 3
) (
	input  wire logic         clk,    // Link clock
	input  wire logic         reset,  // Synchronous, active high
	input  wire logic         bypass, // Pass samples straight through
	input  wire logic [W-1:0] d,      // Synchronised samples
	output logic      [W-1:0] q       // Filtered lines
);
	logic [W-1:0][DEPTH-1:0] hist_r;

	if (DEPTH < 2)
	begin : g_bad
		$error("tsr_filt needs DEPTH of at least 2");
	end

	for (genvar i = 0; i < W; i++)
	begin : g_bit
		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				hist_r[i] <= '1;
				q[i]      <= 1'b1;
			end
			else
			begin
				hist_r[i] <= {hist_r[i][DEPTH-2:0], d[i]};
				// Unless bypassed, spikes shorter than DEPTH samples never reach q
				if (bypass || hist_r[i] == {DEPTH{d[i]}})
					q[i] <= d[i];
			end
		end
	end
endmodule

//--- rtl/tsr_pkg.sv
package tsr_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ         = 10;
	localparam int PERIOD_US       = 400;
	localparam int CONV_US         = 25;
	localparam int SAMPLE_DLY_US   = 3;
	localparam int SLOW_PERIOD_MS  = 800;
	localparam int PERIOD_CYC      = PERIOD_US * CLK_MHZ;
	localparam int CONV_CYC        = CONV_US * CLK_MHZ;
	localparam int SAMPLE_DLY_CYC  = SAMPLE_DLY_US * CLK_MHZ;
	localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int PER_W           = 24;
	localparam int TMR_W           = 9;

	// ------------------------------------------------------------
	// Registers and fields
	// ------------------------------------------------------------
	localparam logic [3:0] BUS_ADDR_HI   = 4'h9;
	localparam logic [1:0] SEL_TEMP      = 2'h0;
	localparam logic [1:0] SEL_CFG       = 2'h1;
	localparam logic [7:0] PTR_RESET     = 8'h00;
	localparam logic [7:0] CFG_RESET     = 8'h40;
	localparam logic [9:0] RESULT_RESET  = 10'h000;
	localparam int         CFG_ONESHOT   = 2;
	localparam logic [3:0] ACK_CNT       = 4'h8;
	localparam logic [3:0] SLOT_END      = 4'h9;

	typedef enum logic [1:0] {
		ASEL_LOW  = 2'h0,
		ASEL_HIGH = 2'h1,
		ASEL_OPEN = 2'h2
	} tsr_asel_t;

	typedef enum logic [1:0] {
		SCH_WAIT  = 2'b00,
		SCH_DELAY = 2'b01,
		SCH_CONV  = 2'b11,
		SCH_HALT  = 2'b10
	} tsr_sch_t;

	typedef enum logic [1:0] {
		LNK_IDLE  = 2'b00,
		LNK_ADDR  = 2'b01,
		LNK_WRITE = 2'b11,
		LNK_READ  = 2'b10
	} tsr_lnk_t;

	typedef struct packed {
		logic       full_powerdown_bit;
		logic       glitch_filter_enable;
		logic [5:0] factory_test;
	} tsr_cfg_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} tsr_pins_t;

	// Low three address bits per variant and select level
	function automatic logic [6:0] tsr_bus_addr(input logic [1:0] variant,
		input tsr_asel_t sel);
		logic [2:0] low;
		low = 3'h0;
		case (variant)
			2'h0: low = (sel == ASEL_LOW) ? 3'h1 :
				(sel == ASEL_HIGH) ? 3'h2 : 3'h0;
			2'h1: low = (sel == ASEL_LOW) ? 3'h5 :
				(sel == ASEL_HIGH) ? 3'h6 : 3'h4;
			2'h2: low = 3'h3;
			default: low = 3'h7;
		endcase
		return {BUS_ADDR_HI, low};
	endfunction

endpackage

//--- rtl/tsr_sync.sv
`timescale 1ns/1ps
module tsr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk, // Destination clock
	input  wire logic [W-1:0] d,   // Asynchronous level
	output logic      [W-1:0] q    // Synchronised level
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk)
	begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule

//--- rtl/tsr_top.sv
// Behaviour
// - first written byte loads register pointer
// - pointer bits 1:0 pick result or config
// - config bit 7 set means full power-down
// - config bit 6 clear bypasses line filters
// - reset: pointer to result, config 40h
// - ten-bit result read as two bytes
// - address 1001 plus low bits from variant and select pin
// - shift address MSB first, then direction
// - nine clocks per byte, slave acks
// - data rising while clock high is stop
// - direction fixed until next start
// - pointer-only write leaves data registers alone
// - config write stores one data byte
// - pointer survives read transactions
// - convert every 400 us, idle between
// - read aborts conversion, restart after read
// - read between conversions triggers conversion
// - power-down keeps serial interface readable
// - write in power-down does one conversion
// - variant: one-shot bit, no bus triggers, 800 ms
// - conversion lasts 25 us, then loads result
// - bus access starts conversion 3 us after stop
`timescale 1ns/1ps
module tsr_top
	import tsr_pkg::*;
#(
	parameter int VARIANT         = 0,
	parameter bit REV_B           = 1'b0,
	parameter int SLOW_PERIOD     = SLOW_PERIOD_CYC,
	parameter int FILT_DEPTH      = 3
) (
	input  wire logic        clk,                // 10 MHz core clock
	input  wire logic        reset,              // Synchronous, active high
	input  wire logic        link_clk,           // Line sampling clock
	input  wire logic        scl_i,              // Serial clock pin
	input  wire logic        sda_i,              // Serial data pin level
	output logic             sda_o,              // Serial data drive value
	output logic             sda_oe,             // High while pulling data low
	input  wire tsr_asel_t   address_select_pin, // Three-level address strap
	input  wire logic [9:0]  adc_result,         // Converter output code
	output logic             conv_start,         // Pulse: conversion begins
	output logic             conv_abort,         // Pulse: conversion dropped
	output logic             sensor_active,      // Converter powered
	output logic             full_powerdown      // Full power-down state
);
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (VARIANT < 0 || VARIANT > 3)
	begin : g_bad_variant
		$error("tsr_top VARIANT must be 0 to 3");
	end
	if (SLOW_PERIOD < 2 || SLOW_PERIOD >= (1 << PER_W))
	begin : g_bad_period
		$error("tsr_top SLOW_PERIOD out of counter range");
	end

	localparam logic [PER_W-1:0] PER_LIM = REV_B ?
		PER_W'(SLOW_PERIOD - 1) : PER_W'(PERIOD_CYC - 1);
	localparam logic [TMR_W-1:0] DLY_LIM  = TMR_W'(SAMPLE_DLY_CYC - 1);
	localparam logic [TMR_W-1:0] CONV_LIM = TMR_W'(CONV_CYC - 1);
	localparam logic [1:0]       VAR_CODE = 2'(VARIANT);

	// ------------------------------------------------------------
	// Link domain: pin sampling and reset
	// ------------------------------------------------------------
	logic       lrst;
	logic       res_tgl_r;
	logic       res_tgl_s;
	tsr_pins_t  pins_s;
	tsr_pins_t  pins_f;
	tsr_asel_t  asel_s;
	logic [1:0] asel_raw;
	tsr_cfg_t   cfg_r;
	logic [9:0] res_r;

	tsr_sync #(.W(6)) u_lsync (
		.clk (link_clk),
		.d   ({reset, res_tgl_r, address_select_pin, scl_i, sda_i}),
		.q   ({lrst, res_tgl_s, asel_raw, pins_s})
	);
	assign asel_s = tsr_asel_t'(asel_raw);

	tsr_filt #(.W(2), .DEPTH(FILT_DEPTH)) u_filt (
		.clk    (link_clk),
		.reset  (lrst),
		.bypass (!cfg_r.glitch_filter_enable),
		.d      (pins_s),
		.q      (pins_f)
	);

	// ------------------------------------------------------------
	// Link domain: line conditions
	// ------------------------------------------------------------
	logic scl_p_r;
	logic sda_p_r;
	logic start_c;
	logic stop_c;
	logic rise_c;
	logic fall_c;

	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end
		else
		begin
			scl_p_r <= pins_f.scl;
			sda_p_r <= pins_f.sda;
		end
	end

	assign start_c = scl_p_r && pins_f.scl && sda_p_r && !pins_f.sda;
	assign stop_c  = scl_p_r && pins_f.scl && !sda_p_r && pins_f.sda;
	assign rise_c  = !scl_p_r && pins_f.scl;
	assign fall_c  = scl_p_r && !pins_f.scl;

	// ------------------------------------------------------------
	// Link domain: protocol engine
	// ------------------------------------------------------------
	tsr_lnk_t   lnk_r;
	logic [3:0] cnt_r;
	logic [7:0] rx_r;
	logic [7:0] tx_r;
	logic       rw_r;
	logic       nack_r;
	logic       rd_idx_r;
	logic       sda_oe_r;
	logic [7:0] ptr_r;
	logic [9:0] res_lk_r;
	logic       addr_hit;
	logic       ack_edge;
	logic       slot_edge;
	logic [7:0] rd_byte;

	assign addr_hit  = rx_r[7:1] == tsr_bus_addr(VAR_CODE, asel_s);
	assign ack_edge  = fall_c && cnt_r == ACK_CNT;
	assign slot_edge = fall_c && cnt_r == SLOT_END;

	// Byte served for the current read position
	function automatic logic [7:0] read_byte(input logic [1:0] sel,
		input logic idx, input logic [9:0] res, input tsr_cfg_t cfg);
		logic [7:0] b;
		b = 8'h00;
		if (sel == SEL_TEMP)
			b = idx ? {res[1:0], 6'h00} : res[9:2];
		else if (sel == SEL_CFG)
			b = cfg;
		return b;
	endfunction

	assign rd_byte = read_byte(ptr_r[1:0], rd_idx_r, res_lk_r, cfg_r);

	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			lnk_r    <= LNK_IDLE;
			cnt_r    <= 4'h0;
			rx_r     <= 8'h00;
			tx_r     <= 8'h00;
			rw_r     <= 1'b0;
			nack_r   <= 1'b0;
			rd_idx_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end
		else if (start_c)
		begin
			lnk_r    <= LNK_ADDR;
			cnt_r    <= 4'h0;
			sda_oe_r <= 1'b0;
		end
		else if (stop_c)
		begin
			lnk_r    <= LNK_IDLE;
			sda_oe_r <= 1'b0;
		end
		else if (rise_c && lnk_r != LNK_IDLE)
		begin
			if (cnt_r < ACK_CNT)
				rx_r <= {rx_r[6:0], pins_f.sda};
			if (cnt_r == ACK_CNT && lnk_r == LNK_READ)
				nack_r <= pins_f.sda;
			cnt_r <= cnt_r + 4'h1;
		end
		else if (ack_edge)
		begin
			unique case (lnk_r)
				LNK_ADDR:
				begin
					if (addr_hit)
					begin
						sda_oe_r <= 1'b1;
						rw_r     <= rx_r[0];
					end
					else
						lnk_r <= LNK_IDLE;
				end
				LNK_WRITE: sda_oe_r <= 1'b1;
				LNK_READ:  sda_oe_r <= 1'b0;
				LNK_IDLE:  sda_oe_r <= 1'b0;
			endcase
		end
		else if (slot_edge)
		begin
			cnt_r <= 4'h0;
			unique case (lnk_r)
				LNK_ADDR:
				begin
					if (rw_r)
					begin
						lnk_r    <= LNK_READ;
						rd_idx_r <= 1'b1;
						tx_r     <= {rd_byte[6:0], 1'b0};
						sda_oe_r <= !rd_byte[7];
					end
					else
					begin
						lnk_r    <= LNK_WRITE;
						sda_oe_r <= 1'b0;
					end
				end
				LNK_READ:
				begin
					// Master nack ends the byte stream
					if (nack_r)
					begin
						lnk_r    <= LNK_IDLE;
						sda_oe_r <= 1'b0;
					end
					else
					begin
						rd_idx_r <= !rd_idx_r;
						tx_r     <= {rd_byte[6:0], 1'b0};
						sda_oe_r <= !rd_byte[7];
					end
				end
				LNK_WRITE: sda_oe_r <= 1'b0;
				LNK_IDLE:  sda_oe_r <= 1'b0;
			endcase
		end
		else if (fall_c && lnk_r == LNK_READ && cnt_r != 4'h0)
		begin
			// Data changes only while the clock is low
			sda_oe_r <= !tx_r[7];
			tx_r     <= {tx_r[6:0], 1'b0};
		end
		if (!start_c && !stop_c && slot_edge && lnk_r == LNK_ADDR && rw_r)
			rd_idx_r <= 1'b1;
		if (start_c)
			rd_idx_r <= 1'b0;
	end

	assign sda_oe = sda_oe_r;
	assign sda_o  = 1'b0;

	// ------------------------------------------------------------
	// Link domain: pointer and configuration
	// ------------------------------------------------------------
	logic first_r;
	logic oneshot_tgl_r;

	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			ptr_r         <= PTR_RESET;
			cfg_r         <= tsr_cfg_t'(CFG_RESET);
			first_r       <= 1'b0;
			oneshot_tgl_r <= 1'b0;
		end
		else if (start_c || stop_c)
			first_r <= 1'b1;
		else if (ack_edge && lnk_r == LNK_WRITE)
		begin
			first_r <= 1'b0;
			if (first_r)
				ptr_r <= rx_r;
			else if (ptr_r[1:0] == SEL_CFG)
			begin
				cfg_r <= tsr_cfg_t'(rx_r);
				if (REV_B && rx_r[CFG_ONESHOT])
					oneshot_tgl_r <= !oneshot_tgl_r;
			end
			// Bytes aimed at the result register are dropped
		end
	end

	// ------------------------------------------------------------
	// Link domain: transaction status toward the core
	// ------------------------------------------------------------
	logic rd_busy_r;
	logic wr_act_r;
	logic rd_tgl_r;
	logic wr_tgl_r;
	logic res_seen_r;

	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			rd_busy_r <= 1'b0;
			wr_act_r  <= 1'b0;
			rd_tgl_r  <= 1'b0;
			wr_tgl_r  <= 1'b0;
		end
		else if (start_c || stop_c)
		begin
			// A repeated start also closes the transaction
			if (rd_busy_r)
				rd_tgl_r <= !rd_tgl_r;
			if (wr_act_r)
				wr_tgl_r <= !wr_tgl_r;
			rd_busy_r <= 1'b0;
			wr_act_r  <= 1'b0;
		end
		else if (slot_edge && lnk_r == LNK_ADDR)
		begin
			rd_busy_r <= rw_r;
			wr_act_r  <= !rw_r;
		end
	end

	// Result held still while a read is running, so both bytes agree
	always_ff @(posedge link_clk)
	begin
		if (lrst)
		begin
			res_lk_r   <= RESULT_RESET;
			res_seen_r <= 1'b0;
		end
		else if (res_tgl_s != res_seen_r && !rd_busy_r)
		begin
			res_lk_r   <= res_r;
			res_seen_r <= res_tgl_s;
		end
	end

	// ------------------------------------------------------------
	// Core domain: crossings from the link
	// ------------------------------------------------------------
	logic       pd_s;
	logic       rd_busy_s;
	logic [2:0] ev_s;
	logic [2:0] ev_p_r;
	logic       wr_done;
	logic       rd_done;
	logic       oneshot;

	tsr_sync #(.W(5)) u_csync (
		.clk (clk),
		.d   ({cfg_r.full_powerdown_bit, rd_busy_r,
			wr_tgl_r, rd_tgl_r, oneshot_tgl_r}),
		.q   ({pd_s, rd_busy_s, ev_s})
	);

	always_ff @(posedge clk)
	begin
		if (reset)
			ev_p_r <= 3'h0;
		else
			ev_p_r <= ev_s;
	end

	assign wr_done = ev_s[2] ^ ev_p_r[2];
	assign rd_done = ev_s[1] ^ ev_p_r[1];
	assign oneshot = ev_s[0] ^ ev_p_r[0];

	// ------------------------------------------------------------
	// Core domain: conversion scheduler
	// ------------------------------------------------------------
	tsr_sch_t         sch_r;
	tsr_sch_t         sch_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [PER_W-1:0] per_r;
	logic             trig;
	logic             abort;
	logic             tmr_done;
	logic             per_done;
	logic             enter_conv;

	// Reads in power-down stay passive; only writes wake the converter
	assign trig = (!REV_B && (wr_done || (rd_done && !pd_s)))
		|| oneshot;
	assign abort    = !REV_B && rd_busy_s;
	assign per_done = per_r == PER_LIM;
	assign tmr_done = (sch_r == SCH_DELAY) ? tmr_r == DLY_LIM :
		tmr_r == CONV_LIM;

	always_comb
	begin
		sch_nxt = sch_r;
		unique case (sch_r)
			SCH_WAIT:
				if (trig)
					sch_nxt = SCH_DELAY;
				else if (pd_s)
					sch_nxt = SCH_HALT;
				else if (per_done && !abort)
					sch_nxt = SCH_CONV;
			SCH_DELAY:
				if (tmr_done)
					sch_nxt = SCH_CONV;
			SCH_CONV:
				if (abort)
					sch_nxt = SCH_WAIT;
				else if (tmr_done)
					sch_nxt = pd_s ? SCH_HALT : SCH_WAIT;
			SCH_HALT:
				if (trig)
					sch_nxt = SCH_DELAY;
				else if (!pd_s)
					sch_nxt = SCH_WAIT;
		endcase
	end

	assign enter_conv = sch_nxt == SCH_CONV && sch_r != SCH_CONV;

	always_ff @(posedge clk)
	begin
		if (reset)
			sch_r <= SCH_WAIT;
		else
			sch_r <= sch_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (reset || sch_nxt != sch_r)
			tmr_r <= '0;
		else if (!tmr_done)
			tmr_r <= tmr_r + TMR_W'(1);
	end

	// Period measured from each conversion start
	always_ff @(posedge clk)
	begin
		if (reset || enter_conv)
			per_r <= '0;
		else if (!per_done)
			per_r <= per_r + PER_W'(1);
	end

	// Aborted conversions leave the last good result in place
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			res_r     <= RESULT_RESET;
			res_tgl_r <= 1'b0;
		end
		else if (sch_r == SCH_CONV && tmr_done && !abort)
		begin
			res_r     <= adc_result;
			res_tgl_r <= !res_tgl_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			conv_start <= 1'b0;
			conv_abort <= 1'b0;
		end
		else
		begin
			conv_start <= enter_conv;
			conv_abort <= sch_r == SCH_CONV && abort;
		end
	end

	assign sensor_active  = sch_r == SCH_CONV;
	assign full_powerdown = sch_r == SCH_HALT;
endmodule

//--- tb/test_temp_sensor_i2c_register_slave.sv
`timescale 1ns/1ps
module test_temp_sensor_i2c_register_slave
	import tsr_pkg::*;
	;
	logic       clk;
	logic       reset;
	logic       link_clk;
	logic       scl;
	logic       sda_m;
	logic       sda;
	logic       sda_o;
	logic       sda_oe;
	tsr_asel_t  asel;
	logic [9:0] adc;
	logic       conv_start;
	logic       conv_abort;
	logic       sensor_active;
	logic       full_powerdown;
	logic [6:0] addr;
	logic [7:0] rb [2];
	logic       ack;
	int         num_errors;
	int         total_checks;
	int         starts;
	int         aborts;
	int         n;
	// Pull-up: a released line reads high
	assign sda = sda_m & ~sda_oe;
	tsr_top u_tsr_top (.clk(clk), .reset(reset), .link_clk(link_clk),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.address_select_pin(asel), .adc_result(adc),
		.conv_start(conv_start), .conv_abort(conv_abort),
		.sensor_active(sensor_active), .full_powerdown(full_powerdown));
	tsr_master u_tsr_master (.sda(sda), .scl(scl), .sda_m(sda_m));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#37;
		forever #62.5 link_clk = ~link_clk;
	end
	always @(posedge clk)
	begin
		if (conv_start === 1'b1)
			starts++;
		if (conv_abort === 1'b1)
			aborts++;
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_conv(input int lim);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
			if (n > lim)
			begin
				num_errors++;
				test_done();
			end
		end
		while (conv_start !== 1'b1);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d, input bit two);
		u_tsr_master.start();
		u_tsr_master.send({addr, 1'b0}, ack);
		chk(16'(ack), 16'h0000);
		u_tsr_master.send(p, ack);
		chk(16'(ack), 16'h0000);
		if (two)
		begin
			u_tsr_master.send(d, ack);
			chk(16'(ack), 16'h0000);
		end
		u_tsr_master.stop();
	endtask
	task automatic rd(input int cnt);
		u_tsr_master.start();
		u_tsr_master.send({addr, 1'b1}, ack);
		chk(16'(ack), 16'h0000);
		for (int i = 0; i < cnt; i++)
			u_tsr_master.recv(i == cnt - 1, rb[i]);
		u_tsr_master.stop();
	endtask
	task automatic chk_temp(input logic [9:0] v);
		rd(2);
		chk(16'(rb[0]), 16'(v[9:2]));
		chk(16'(rb[1]), 16'({v[1:0], 6'h00}));
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		chk_temp(RESULT_RESET);
		chk(16'(sda_o), 16'h0000);
		wait_conv(100);
		repeat (CONV_CYC + 10) @(negedge clk);
		chk_temp(adc);
		$display("test_reset done");
	endtask
	task automatic test_regs();
		wr(8'h01, 8'h00, 0);
		rd(1);
		chk(16'(rb[0]), 16'(CFG_RESET));
		wr(8'h01, 8'h00, 1);
		rd(1);
		chk(16'(rb[0]), 16'h0000);
		rd(1);
		chk(16'(rb[0]), 16'h0000);
		wr(8'h01, 8'h40, 1);
		wr(8'h00, 8'hFF, 1);
		wr(8'h01, 8'h00, 0);
		rd(1);
		chk(16'(rb[0]), 16'h0040);
		wr(8'h02, 8'h00, 0);
		rd(1);
		chk(16'(rb[0]), 16'h0000);
		$display("test_regs done");
	endtask
	task automatic test_addr();
		logic [2:0] low [3];
		low = '{3'h1, 3'h2, 3'h0};
		for (int i = 0; i < 3; i++)
		begin
			@(negedge clk);
			asel = tsr_asel_t'(2'(i));
			repeat (10) @(negedge clk);
			addr = {BUS_ADDR_HI, low[i]};
			wr(8'h00, 8'h00, 0);
		end
		u_tsr_master.start();
		u_tsr_master.send({BUS_ADDR_HI, 3'h1, 1'b0}, ack);
		chk(16'(ack), 16'h0001);
		u_tsr_master.stop();
		asel = ASEL_HIGH;
		addr = {BUS_ADDR_HI, 3'h2};
		repeat (10) @(negedge clk);
		$display("test_addr done");
	endtask
	task automatic test_abort();
		int a;
		wait_conv(PERIOD_CYC + 100);
		// Converter samples at the end, so the new code is not yet stored
		adc = 10'h2C6;
		a = aborts;
		chk_temp(10'h155);
		chk(16'(aborts - a), 16'h0001);
		wait_conv(100);
		repeat (CONV_CYC + 10) @(negedge clk);
		chk_temp(10'h2C6);
		$display("test_abort done");
	endtask
	task automatic test_period();
		wait_conv(PERIOD_CYC + 100);
		wait_conv(PERIOD_CYC + 100);
		chk(16'(n), 16'(PERIOD_CYC));
		$display("test_period done");
	endtask
	task automatic test_pd();
		int s;
		int d;
		wr(8'h01, 8'hC0, 1);
		repeat (400) @(negedge clk);
		chk(16'(full_powerdown), 16'h0001);
		s = starts;
		rd(1);
		chk(16'(rb[0]), 16'h00C0);
		chk(16'(starts - s), 16'h0000);
		adc = 10'h3A1;
		wr(8'h00, 8'h00, 0);
		wait_conv(100);
		d = int'(($time - u_tsr_master.t_stop) / 100);
		chk(16'(d >= SAMPLE_DLY_CYC && d <= SAMPLE_DLY_CYC + 12), 16'h0001);
		repeat (CONV_CYC + 20) @(negedge clk);
		chk(16'(full_powerdown), 16'h0001);
		chk(16'(sensor_active), 16'h0000);
		chk_temp(10'h3A1);
		wr(8'h01, 8'h40, 1);
		repeat (400) @(negedge clk);
		chk(16'(full_powerdown), 16'h0000);
		$display("test_pd done");
	endtask
	initial
	begin
		reset = 1'b1;
		adc = 10'h155;
		asel = ASEL_HIGH;
		addr = {BUS_ADDR_HI, 3'h2};
		num_errors = 0;
		total_checks = 0;
		starts = 0;
		aborts = 0;
		n = 0;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		repeat (10) @(negedge clk);
		test_reset();
		test_regs();
		test_addr();
		test_abort();
		test_period();
		test_pd();
		test_done();
	end
endmodule

//--- tb/tsr_master.sv
`timescale 1ns/1ps
module tsr_master (
	input  wire logic sda,   // Wired data level
	output logic      scl,   // Clock, high while idle
	output logic      sda_m  // Data drive, 1 releases
);
	// Half period of 8 link clocks outlasts the filter latency
	localparam int HP = 1000;
	time t_stop;
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
		t_stop = 0;
	end
	task automatic start();
		#(HP) sda_m = 1'b0;
		#(HP) scl = 1'b0;
	endtask
	task automatic bit_out(input logic b);
		#(HP / 2) sda_m = b;
		#(HP / 2) scl = 1'b1;
		#(HP) scl = 1'b0;
	endtask
	task automatic bit_in(output logic b);
		#(HP / 2) sda_m = 1'b1;
		#(HP / 2) scl = 1'b1;
		#(HP / 2) b = sda;
		#(HP / 2) scl = 1'b0;
	endtask
	task automatic send(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_out(v[i]);
		bit_in(ack);
	endtask
	task automatic recv(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			bit_in(v[i]);
		bit_out(last);
	endtask
	task automatic stop();
		#(HP / 2) sda_m = 1'b0;
		#(HP / 2) scl = 1'b1;
		#(HP) sda_m = 1'b1;
		t_stop = $time;
		#(HP);
	endtask
endmodule

//--- tb/tsr_top_sva.sv
`timescale 1ns/1ps
module tsr_top_sva
	import tsr_pkg::*;
(
	input wire logic clk,            // Core clock
	input wire logic reset,          // Sync reset
	input wire logic link_clk,       // Link clock
	input wire logic scl_i,          // Clock pin
	input wire logic sda_o,          // Data value
	input wire logic sda_oe,         // Data enable
	input wire logic conv_start,     // Conversion begins
	input wire logic conv_abort,     // Conversion dropped
	input wire logic sensor_active,  // Converter on
	input wire logic full_powerdown  // Halted
);
	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	localparam int CMIN = CONV_CYC - 3;
	localparam int CMAX = CONV_CYC + 2;
	localparam int PMAX = PERIOD_CYC + 2;
	int   act_cnt;
	int   gap_cnt;
	logic abort_seen;
	always_ff @(posedge clk)
	begin
		act_cnt <= (reset || !sensor_active) ? 0 : act_cnt + 1;
	end
	// Halt stops the schedule, so the gap restarts there
	always_ff @(posedge clk)
	begin
		gap_cnt <= (reset || conv_start || full_powerdown) ? 0 : gap_cnt + 1;
	end
	always_ff @(posedge clk)
	begin
		if (reset || conv_start)
			abort_seen <= 1'b0;
		else if (conv_abort)
			abort_seen <= 1'b1;
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_start_pulse: assert property (@(posedge clk) disable iff (reset)
		conv_start |=> !conv_start) else $error("start pulse too long");
	chk_abort_pulse: assert property (@(posedge clk) disable iff (reset)
		conv_abort |=> !conv_abort) else $error("abort pulse too long");
	chk_abort_in_conv: assert property (@(posedge clk) disable iff (reset)
		conv_abort |-> sensor_active || $past(sensor_active))
		else $error("abort outside conversion");
	chk_start_active: assert property (@(posedge clk) disable iff (reset)
		conv_start |-> ##[0:1] sensor_active) else $error("start without power");
	chk_conv_max: assert property (@(posedge clk) disable iff (reset)
		act_cnt <= CMAX) else $error("conversion too long");
	chk_conv_min: assert property (@(posedge clk) disable iff (reset)
		$fell(sensor_active) && !abort_seen && !conv_abort
		|-> $past(act_cnt) >= CMIN) else $error("conversion too short");
	chk_period_max: assert property (@(posedge clk) disable iff (reset)
		gap_cnt <= PMAX) else $error("periodic conversion missed");
	chk_halt_quiet: assert property (@(posedge clk) disable iff (reset)
		!(full_powerdown && sensor_active)) else $error("converting in halt");
	chk_open_drain: assert property (@(posedge clk) disable iff (reset)
		sda_oe |-> !sda_o) else $error("data driven high");
	chk_sda_scl_low: assert property (@(posedge link_clk) disable iff (reset)
		$changed(sda_oe) |-> !scl_i) else $error("data moved, clock high");
	cover property (@(posedge clk) conv_abort);
	cover property (@(posedge clk) $rose(full_powerdown));
	cover property (@(posedge link_clk) $rose(sda_oe));
endmodule
bind tsr_top tsr_top_sva u_tsr_top_sva (.clk(clk), .reset(reset),
	.link_clk(link_clk), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.conv_start(conv_start), .conv_abort(conv_abort),
	.sensor_active(sensor_active), .full_powerdown(full_powerdown));
